// file: hdl/baud_div_if.sv
// Interface carrying divider settings and the enable pulses they produce.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface baud_div_if;
  logic       tick;
  logic [7:0] prediv;
  logic [2:0] postdiv;
  logic       baud_en;
  modport ctrl (output tick, output prediv, output postdiv, input baud_en);
  modport div  (input tick, input prediv, input postdiv, output baud_en);
endinterface
`default_nettype wire

// file: hdl/baud_divider.sv
// Two-stage baud enable divider: predivider then post-divider.
// Assumes tick is a one-cycle enable at the divided crystal clock rate.
`timescale 1ns/1ps
`default_nettype none
module baud_divider (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Settings and output
  baud_div_if.div   bd
);
  logic [7:0] pre_cnt_reg;
  logic [2:0] post_cnt_reg;
  logic       pre_wrap;
  logic       post_wrap;
  logic       out_reg;

  // Reserved codes below the minimum are clamped so the divider never stalls.
  assign pre_wrap  = bd.tick && (pre_cnt_reg + 8'h01 >= bd.prediv);
  assign post_wrap = pre_wrap && (post_cnt_reg + 3'h1 >= bd.postdiv);
  assign bd.baud_en = out_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_cnt_reg  <= 8'h00;
      post_cnt_reg <= 3'h0;
      out_reg      <= 1'b0;
    end else begin
      out_reg <= post_wrap; // RL15
      if (bd.tick) begin
        pre_cnt_reg <= pre_wrap ? 8'h00 : pre_cnt_reg + 8'h01; // RL4
      end
      if (pre_wrap) begin
        post_cnt_reg <= post_wrap ? 3'h0 : post_cnt_reg + 3'h1; // RL3
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/tx_cfg_pkg.sv
// Constants of the transmitter clock and power configuration register bank.
// Assumes an 8-bit register port with a 5-bit register address.
package tx_cfg_pkg;
  localparam logic [4:0] addr_clock_output_start_delay_baud_postdiv = 5'h01;
  localparam logic [4:0] addr_baud_predivider           = 5'h02;
  localparam logic [4:0] addr_power_down_select         = 5'h03;
  localparam logic [4:0] addr_gaussian_shaping_step     = 5'h04;
  localparam logic [4:0] addr_amp_boost_control         = 5'h05;
  localparam logic [4:0] addr_amp_drive_strength        = 5'h06;
  localparam int         delay_msb                      = 7;
  localparam int         delay_lsb                      = 6;
  localparam int         postdiv_msb                    = 2;
  localparam logic [1:0] delay_reset                    = 2'h2;
  localparam logic [2:0] postdiv_reset                  = 3'h1;
  localparam logic [2:0] postdiv_max                    = 3'h5;
  localparam logic [7:0] prediv_reset                   = 8'h03;
  localparam logic [7:0] prediv_min                     = 8'h03;
  localparam logic [1:0] pwdn_shutdown                  = 2'h0;
  localparam logic [1:0] pwdn_standby                   = 2'h1;
  localparam logic [1:0] pwdn_quick                     = 2'h2;
  localparam logic [1:0] pwdn_revert                    = 2'h3;
  localparam logic [5:0] step_reset                     = 6'h00;
  localparam logic [2:0] boost_rsv_reset                = 3'h4;
  localparam logic [2:0] drive_rsv_reset                = 3'h4;
  localparam logic [2:0] drive_reset                    = 3'h0;
  localparam logic [9:0] delay_base_cycles              = 10'h040;
  localparam logic [1:0] xdiv_reset                     = 2'h1;
  localparam logic [2:0] xdiv_base                      = 3'h4;
endpackage

// file: hdl/tx_clock_power_config_regs.sv
// Clock-output delay, baud divider, power-down and amplifier registers.
// Assumes a synchronous 8-bit register port and a low-power request level.
//
// Behaviour
// RL1: Clock output stays idle 64/128/256/512 cycles by delay code; resets to 2.
// RL2: Delay counts divided crystal cycles, only on shutdown to normal transition.
// RL3: Post-divider bits 2:0 divide by code 1..5; resets to 1.
// RL4: Predivider divides by its code 3..255; resets to 3.
// RL5: Host must not program predivider codes 0, 1 or 2.
// RL6: Shutdown select turns off oscillator, synthesiser and amplifier.
// RL7: Standby keeps oscillator, turns off synthesiser and amplifier.
// RL8: Quick resume keeps oscillator and synthesiser, turns off amplifier.
// RL9: A written power-down code 3 becomes code 2.
// RL10: Six-bit shaping step in bits 5:0, reset zero, feeds modulator.
// RL11: Boost bit 0 selects boosted amplifier power; reset clear.
// RL12: Host writes reserved bits with their reset values.
// RL13: Driver count field enables code plus one amplifier drivers.
// RL14: Digital tick is crystal clock divided by 4, 5, 6 or 7.
// RL15: Baud rate is predivider then post-divider, product ratio.
// RL16: Fields read back as written; unused bits read zero.
`timescale 1ns/1ps
`default_nettype none
module tx_clock_power_config_regs (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Crystal divider setting and power state request
  input  wire logic [1:0] crystal_clock_divider,
  input  wire logic       low_power_req,
  // Block enables
  output logic            crystal_oscillator_en,
  output logic            synth_en,
  output logic            power_amplifier_en,
  // Analog settings
  output logic      [5:0] shaping_step,
  output logic            amp_boost,
  output logic      [7:0] amp_driver_enables,
  // Clocks
  output logic            baud_en,
  output logic            clock_output_pin
);
  typedef enum logic [1:0] {st_off, st_wait, st_run} clk_state_type;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [1:0]    delay_reg;
  logic [2:0]    postdiv_reg;
  logic [7:0]    prediv_reg;
  logic [1:0]    pwdn_reg;
  logic [5:0]    step_reg;
  logic [2:0]    boost_reg;
  logic [2:0]    drive_rsv_reg;
  logic [2:0]    drive_reg;
  logic [2:0]    xdiv_cnt_reg;
  logic          tick_reg;
  logic [9:0]    wait_cnt_reg;
  logic          clock_output_pin_reg;
  logic          lp_reg;
  clk_state_type state_reg;
  clk_state_type state_next;
  logic [1:0]    pwdn_wdata;
  logic [2:0]    xdiv_last;
  logic [9:0]    delay_cycles;
  logic          in_shutdown;

  assign pwdn_wdata   = (reg_wdata[1:0] == tx_cfg_pkg::pwdn_revert) ?
                        tx_cfg_pkg::pwdn_quick : reg_wdata[1:0]; // RL9
  assign xdiv_last    = tx_cfg_pkg::xdiv_base + {1'b0, crystal_clock_divider} - 3'h1;
  assign delay_cycles = tx_cfg_pkg::delay_base_cycles << delay_reg; // RL1
  assign in_shutdown  = lp_reg && (pwdn_reg == tx_cfg_pkg::pwdn_shutdown);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      delay_reg     <= tx_cfg_pkg::delay_reset;
      postdiv_reg   <= tx_cfg_pkg::postdiv_reset;
      prediv_reg    <= tx_cfg_pkg::prediv_reset;
      pwdn_reg      <= tx_cfg_pkg::pwdn_shutdown;
      step_reg      <= tx_cfg_pkg::step_reset;
      boost_reg     <= tx_cfg_pkg::boost_rsv_reset;
      drive_rsv_reg <= tx_cfg_pkg::drive_rsv_reset;
      drive_reg     <= tx_cfg_pkg::drive_reset;
    end else if (reg_wr) begin
      case (reg_addr)
        tx_cfg_pkg::addr_clock_output_start_delay_baud_postdiv: begin
          delay_reg   <= reg_wdata[tx_cfg_pkg::delay_msb:tx_cfg_pkg::delay_lsb];
          postdiv_reg <= reg_wdata[tx_cfg_pkg::postdiv_msb:0]; // RL3
        end
        tx_cfg_pkg::addr_baud_predivider:       prediv_reg <= reg_wdata; // RL4
        tx_cfg_pkg::addr_power_down_select:     pwdn_reg   <= pwdn_wdata; // RL9
        tx_cfg_pkg::addr_gaussian_shaping_step: step_reg   <= reg_wdata[5:0]; // RL10
        tx_cfg_pkg::addr_amp_boost_control:     boost_reg  <= reg_wdata[2:0]; // RL11
        tx_cfg_pkg::addr_amp_drive_strength: begin
          drive_rsv_reg <= reg_wdata[7:5];
          drive_reg     <= reg_wdata[2:0]; // RL13
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        tx_cfg_pkg::addr_clock_output_start_delay_baud_postdiv: reg_rdata <= {delay_reg, 3'h0, postdiv_reg};
        tx_cfg_pkg::addr_baud_predivider:           reg_rdata <= prediv_reg;
        tx_cfg_pkg::addr_power_down_select:         reg_rdata <= {6'h00, pwdn_reg};
        tx_cfg_pkg::addr_gaussian_shaping_step:     reg_rdata <= {2'h0, step_reg};
        tx_cfg_pkg::addr_amp_boost_control:         reg_rdata <= {5'h00, boost_reg};
        tx_cfg_pkg::addr_amp_drive_strength:        reg_rdata <= {drive_rsv_reg, 2'h0, drive_reg};
        default:                                    reg_rdata <= 8'h00; // RL16
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power state and divided crystal tick
  // ---------------------------------------------------------------
  // The tick is held low while the oscillator is off, so shutdown freezes the baud divider and clears the tick and delay counts.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lp_reg       <= 1'b0;
      xdiv_cnt_reg <= 3'h0;
      tick_reg     <= 1'b0;
    end else begin
      lp_reg <= low_power_req;
      if (in_shutdown) begin
        xdiv_cnt_reg <= 3'h0;
        tick_reg     <= 1'b0;
      end else begin
        xdiv_cnt_reg <= (xdiv_cnt_reg >= xdiv_last) ? 3'h0 : xdiv_cnt_reg + 3'h1; // RL14
        tick_reg     <= (xdiv_cnt_reg >= xdiv_last); // RL14
      end
    end
  end

  // ---------------------------------------------------------------
  // Block enables and analog settings
  // ---------------------------------------------------------------
  // Standby and quick resume differ only in the synthesiser, so one compare covers both.
  assign crystal_oscillator_en = !in_shutdown; // RL6
  assign synth_en              = !(lp_reg && (pwdn_reg != tx_cfg_pkg::pwdn_quick)); // RL7
  assign power_amplifier_en    = !lp_reg; // RL8
  assign shaping_step          = step_reg; // RL10
  assign amp_boost             = boost_reg[0]; // RL11
  // Drivers are enabled from the bottom up, so the count becomes a thermometer code.
  assign amp_driver_enables    = 8'hff >> (3'h7 - drive_reg); // RL13

  // ---------------------------------------------------------------
  // Clock output start delay
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_off:  state_next = in_shutdown ? st_off : st_wait; // RL2
      st_wait: begin
        if (in_shutdown) begin
          state_next = st_off;
        end else if (tick_reg && (wait_cnt_reg + 10'h001 >= delay_cycles)) begin
          state_next = st_run; // RL1
        end
      end
      st_run:  state_next = in_shutdown ? st_off : st_run;
      default: state_next = st_off;
    endcase
  end

  // The delay restarts only from shutdown; standby and quick resume keep toggling.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg    <= st_off;
      wait_cnt_reg <= 10'h000;
      clock_output_pin_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg != st_wait) begin
        wait_cnt_reg <= 10'h000;
      end else if (tick_reg) begin
        wait_cnt_reg <= wait_cnt_reg + 10'h001; // RL2
      end
      if (state_reg != st_run) begin
        clock_output_pin_reg <= 1'b0; // RL1
      end else if (tick_reg) begin
        clock_output_pin_reg <= !clock_output_pin_reg;
      end
    end
  end

  assign clock_output_pin = clock_output_pin_reg;

  // ---------------------------------------------------------------
  // Baud divider
  // ---------------------------------------------------------------
  baud_div_if bd ();

  assign bd.tick    = tick_reg;
  // Reserved codes are replaced here and not at write time, so they still read back
  // exactly as written while the divider keeps running at a legal ratio.
  assign bd.prediv  = (prediv_reg < tx_cfg_pkg::prediv_min) ? tx_cfg_pkg::prediv_min : prediv_reg;
  assign bd.postdiv = (postdiv_reg == 3'h0 || postdiv_reg > tx_cfg_pkg::postdiv_max) ?
                      tx_cfg_pkg::postdiv_reset : postdiv_reg;
  assign baud_en    = bd.baud_en;

  baud_divider u_baud (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bd      (bd)
  );
endmodule
`default_nettype wire

// file: testbench/tx_clock_power_config_regs_assertions.sv
// Port checker for the clock and power configuration bank.
// Assumes it sees only the top module ports and is bound below.
`timescale 1ns/1ps
`default_nettype none
module tx_clock_power_config_regs_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Register port
  input wire logic       reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Controls and outputs
  input wire logic [1:0] crystal_clock_divider,
  input wire logic       low_power_req,
  input wire logic       crystal_oscillator_en,
  input wire logic       synth_en,
  input wire logic       power_amplifier_en,
  input wire logic [5:0] shaping_step,
  input wire logic       amp_boost,
  input wire logic [7:0] amp_driver_enables,
  input wire logic       baud_en,
  input wire logic       clock_output_pin
);
  // Shadows of the write traffic, so each output can be tied to its cause.
  logic       lp_reg;
  logic [1:0] sel_reg;
  logic [2:0] drv_reg;
  logic       boost_reg;
  wire        wr_sel   = reg_wr && reg_addr == tx_cfg_pkg::addr_power_down_select;
  wire        wr_boost = reg_wr && reg_addr == tx_cfg_pkg::addr_amp_boost_control;
  wire        wr_drv   = reg_wr && reg_addr == tx_cfg_pkg::addr_amp_drive_strength;
  wire  [1:0] sel_next = (reg_wdata[1:0] == 2'h3) ? 2'h2 : reg_wdata[1:0];
  always_ff @(posedge clk) begin
    lp_reg <= sys_rst ? 1'b0 : low_power_req;
    if (sys_rst || wr_sel) sel_reg <= sys_rst ? 2'h0 : sel_next;
    if (sys_rst || wr_drv) drv_reg <= sys_rst ? 3'h0 : reg_wdata[2:0];
    if (sys_rst || wr_boost) boost_reg <= sys_rst ? 1'b0 : reg_wdata[0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_amp_off_low: assert property (lp_reg |-> !power_amplifier_en)
    else $error("amplifier on in low power");
  a_shutdown_all_off: assert property (lp_reg && sel_reg == 2'h0 |->
    !crystal_oscillator_en && !synth_en) else $error("shutdown leaves a block on");
  a_standby_osc_only: assert property (lp_reg && sel_reg == 2'h1 |->
    crystal_oscillator_en && !synth_en) else $error("standby enables wrong");
  a_quick_keeps_synth: assert property (lp_reg && sel_reg == 2'h2 |->
    crystal_oscillator_en && synth_en) else $error("quick resume enables wrong");
  a_driver_count: assert property (
    amp_driver_enables == (8'h2 << drv_reg) - 8'h1) else $error("driver enables wrong");
  a_boost_follows: assert property (amp_boost == boost_reg)
    else $error("boost bit wrong");
  a_unmapped_zero: assert property ($past(reg_addr) > 5'h06 || $past(reg_addr) == 5'h00 |->
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_baud_single: assert property (baud_en |=> !baud_en)
    else $error("baud pulse too long");
  a_clock_frozen: assert property ((lp_reg && sel_reg == 2'h0) [*4] |->
    $stable(clock_output_pin)) else $error("clock output moves in shutdown");
endmodule
bind tx_clock_power_config_regs tx_clock_power_config_regs_assertions u_chk (
  .clk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .crystal_clock_divider,
  .low_power_req, .crystal_oscillator_en, .synth_en, .power_amplifier_en, .shaping_step,
  .amp_boost, .amp_driver_enables, .baud_en, .clock_output_pin
);
`default_nettype wire

// file: testbench/tx_clock_power_config_regs_test.sv
// Self-checking bench for the clock and power configuration bank.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
module tx_clock_power_config_regs_test;
  logic       clk, sys_rst, reg_wr, low_power_req, clock_output_pin;
  logic       crystal_oscillator_en, synth_en, power_amplifier_en, amp_boost, baud_en;
  logic [1:0] crystal_clock_divider;
  logic [4:0] reg_addr;
  logic [5:0] shaping_step;
  logic [7:0] reg_wdata, reg_rdata, amp_driver_enables;
  int         n_fail = 0, n_tests = 0, n, t, e, p;
  logic [7:0] mask [7] = '{8'h00, 8'hc7, 8'hff, 8'h03, 8'h3f, 8'h07, 8'he7};
  logic [7:0] rval [7] = '{8'h00, 8'h81, 8'h03, 8'h00, 8'h00, 8'h04, 8'h80};
  tx_clock_power_config_regs uut (
    .clk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .crystal_clock_divider,
    .low_power_req, .crystal_oscillator_en, .synth_en, .power_amplifier_en, .shaping_step,
    .amp_boost, .amp_driver_enables, .baud_en, .clock_output_pin
  );
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    // One idle cycle keeps the strobe from dropping and rising in one time step.
    @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] fold(input logic [4:0] a, input logic [7:0] d);
    fold = (a > 5'h06) ? 8'h00 : d & mask[a[2:0]];
    if (a == 5'h03 && fold == 8'h03) fold = 8'h02;
  endfunction
  function automatic logic [7:0] therm(input logic [2:0] code);
    therm = 8'((16'h2 << code) - 16'h1);
  endfunction
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(posedge clk);
    #1 chk("read data", 16'(reg_rdata), 16'(exp));
  endtask
  // Counts cycles to the next pin change, or to the next baud pulse.
  task automatic gap(input bit pin, output int c);
    logic q;
    q = clock_output_pin;
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while ((pin ? clock_output_pin === q : baud_en !== 1'b1) && c < 10000);
  endtask
  task automatic end_of_test;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The longest run is about 40000 cycles, so this is a hang.
  initial begin
    #2ms n_fail++;
    end_of_test;
  end
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    crystal_clock_divider = 2'h0;
    low_power_req = 1'b0;
    n = $urandom(34689);
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int a = 0; a < 7; a++) rd(5'(a), rval[a]);
    chk("shaping reset", 16'(shaping_step), 16'h0000);
    chk("amp reset", 16'({amp_boost, amp_driver_enables}), 16'h0001);
    wr(5'h03, 8'h03);
    rd(5'h03, 8'h02);
    repeat (40) begin
      n = $urandom_range(9, 1);
      e = $urandom;
      if (n == 2 && e[7:0] < 3) e = 3;
      if (n == 5) e = 32'h4 | e[0];
      if (n == 6) e = 32'h80 | e[2:0];
      wr(5'(n), 8'(e));
      rd(5'(n), fold(5'(n), 8'(e)));
      if (n == 4) chk("shaping step", 16'(shaping_step), 16'(e[5:0]));
      if (n == 5) chk("boost", 16'(amp_boost), 16'(e[0]));
      if (n == 6) chk("driver enables", 16'(amp_driver_enables), 16'(therm(e[2:0])));
    end
    for (int c = 0; c < 4; c++) begin
      wr(5'h03, 8'(c));
      chk("awake", 16'({crystal_oscillator_en, synth_en, power_amplifier_en}), 16'h7);
      low_power_req = 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("oscillator", 16'(crystal_oscillator_en), 16'(c != 0));
      chk("synthesiser", 16'(synth_en), 16'(c >= 2));
      chk("amplifier", 16'(power_amplifier_en), 16'h0);
      low_power_req = 1'b0;
    end
    for (int c = 0; c < 4; c++) begin
      t = 4 + $urandom_range(3, 0);
      crystal_clock_divider = 2'(t - 4);
      wr(5'h01, {2'(c), 6'h01});
      wr(5'h03, 8'h00);
      low_power_req = 1'b1;
      repeat (6) @(posedge clk);
      #1 low_power_req = 1'b0;
      gap(1'b1, n);
      e = t * (64 << c);
      chk("start delay", 16'(n >= e - t && n <= e + 3 * t), 16'h1);
      gap(1'b1, n);
      chk("toggle period", 16'(n), 16'(t));
    end
    for (int i = 0; i < 7; i++) begin
      e = (i == 0) ? 255 : $urandom_range(12, 3);
      n = (i == 0) ? 5 : $urandom_range(5, 1);
      t = 4 + $urandom_range(3, 0);
      crystal_clock_divider = 2'(t - 4);
      wr(5'h02, 8'(e));
      wr(5'h01, 8'(n));
      repeat (3) gap(1'b0, p);
      chk("baud period", 16'(p), 16'(t * e * n));
    end
    end_of_test;
  end
endmodule
`default_nettype wire
